/* File: rtl/sbas_pkg.sv */
// Constants and types shared by the brake and fault sequencer
package sbas_pkg;
  localparam int unsigned CLK_HZ            = 25000000;
  localparam int unsigned TICK_MS           = 10;
  localparam int unsigned TICK_CYCLES       = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TICK_W            = 18;
  localparam logic [5:0]  OFF_DELAY_MAX     = 6'h32;
  localparam logic [5:0]  OFF_DELAY_DEF     = 6'h00;
  localparam logic [6:0]  WAIT_MAX          = 7'h64;
  localparam logic [6:0]  WAIT_DEF          = 7'h32;
  localparam logic [13:0] SPEED_LEVEL_MAX   = 14'h2710;
  localparam logic [13:0] SPEED_LEVEL_DEF   = 14'h0064;
  localparam logic [2:0]  ENABLE_MAP_INPUT  = 3'h0;
  localparam logic [2:0]  ENABLE_MAP_ALWAYS = 3'h7;
  localparam logic [1:0]  PLACE_NONE        = 2'h0;
  localparam logic [1:0]  PLACE_ONE         = 2'h1;
  localparam logic [1:0]  PLACE_TWO         = 2'h2;
  localparam logic [1:0]  PLACE_THREE       = 2'h3;
  localparam logic [2:0]  FAULT_CODE_NONE   = 3'h0;

  typedef enum logic [1:0] {
    SBAS_RUN      = 2'b00,
    SBAS_STOPWAIT = 2'b01,
    SBAS_RUNWAIT  = 2'b10,
    SBAS_OFF      = 2'b11
  } sbas_state_e;
endpackage

/* File: rtl/sbas_tick_counter.sv */
// Down counter of 10 ms ticks with load and expiry flag
`timescale 1ns/1ps
`default_nettype none
module sbas_tick_counter (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       load_i,
  input  wire logic [6:0] count_i,
  input  wire logic       tick_i,
  output logic            done_o
);
  logic [6:0] cnt_reg;
  logic       done_reg;
  wire  logic dec_hit = tick_i && (cnt_reg != 7'h00);

  // Load wins over counting so a new turn-off restarts the wait
  always_ff @(posedge clk_i) begin
    if (rst_i || load_i) begin
      cnt_reg  <= rst_i ? 7'h00 : count_i;
      done_reg <= rst_i ? 1'b0 : (count_i == 7'h00);
    end else if (dec_hit) begin
      cnt_reg  <= cnt_reg - 7'h01;
      done_reg <= (cnt_reg == 7'h01);
    end
  end
  assign done_o = done_reg;
endmodule
`default_nettype wire

/* File: rtl/sbas_sequencer.sv */
// Holding-brake and fault-output sequencer of a servo amplifier
// Function
// - Brake release output low releases brake, high applies it.
// - Placement setting routes brake signal to no output or output one to three.
// - Output circuit is the OR of all signals assigned to it.
// - Standstill turn-off delays motor stop after brake by 0..50 ticks of 10 ms.
// - Delay zero stops motor in the same cycle the brake applies.
// - Standstill delay only at rest; moving turn-off uses speed and wait settings.
// - Alarm stops motor output at once, ignoring the standstill delay.
// - Moving turn-off applies brake when speed drops below level setting.
// - Moving turn-off also applies brake after wait time, whichever first.
// - Speed level above motor maximum is clamped to the maximum.
// - Running brake timing applies for enable removal and for alarms.
// - Fault output low when normal, high once an alarm is detected.
// - Three fault code outputs identify the latched alarm type.
// - Fault clear input clears a latched alarm.
// - Removal of control power clears all alarms.
// - Panel or handheld command also clears alarms.
// - Encoder alarms may stay latched until power is cycled.
// - Enable low runs motor, enable high keeps motor off unless enable map is 7.
// - Motor output turns off on enable removal, alarm or power loss.
// - Enable map 7 forces drive enabled; map 0 uses the input.
`timescale 1ns/1ps
`default_nettype none
module sbas_sequencer (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        drive_enable_n_i,
  input  wire logic [2:0]  enable_input_map_i,
  input  wire logic        fault_clear_in_i,
  input  wire logic        panel_clear_i,
  input  wire logic        alarm_detect_i,
  input  wire logic [2:0]  alarm_type_i,
  input  wire logic        alarm_is_encoder_i,
  input  wire logic [13:0] motor_speed_i,
  input  wire logic [13:0] motor_max_speed_i,
  input  wire logic        motor_stopped_i,
  input  wire logic [5:0]  brake_to_off_delay_i,
  input  wire logic [13:0] brake_speed_level_i,
  input  wire logic [6:0]  brake_wait_time_i,
  input  wire logic [1:0]  brake_output_place_i,
  input  wire logic [2:0]  other_out_active_i,
  output logic             motor_output_on_o,
  output logic             brake_release_out_o,
  output logic [2:0]       output_circuit_n_o,
  output logic             fault_out_n_o,
  output logic             fault_code_bit_one_o,
  output logic             fault_code_bit_two_o,
  output logic             fault_code_bit_three_o
);
  sbas_pkg::sbas_state_e state_reg;
  sbas_pkg::sbas_state_e state_next;
  logic [sbas_pkg::TICK_W-1:0] presc_reg;
  logic        tick_reg;
  logic        fault_reg;
  logic        enc_fault_reg;
  logic [2:0]  code_reg;
  logic        motor_reg;
  logic        release_reg;
  logic [2:0]  circ_n_reg;
  logic        wait_done;
  logic        delay_done;

  // Prescaler for the 10 ms time base
  wire logic presc_end =
    (presc_reg == sbas_pkg::TICK_W'(sbas_pkg::TICK_CYCLES - 1));
  always_ff @(posedge clk_i) begin
    if (rst_i || presc_end) begin
      presc_reg <= '0;
    end else begin
      presc_reg <= presc_reg + 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    tick_reg <= !rst_i && presc_end;
  end

  // Enable qualification; map 7 means permanently enabled
  wire logic enable_req = (enable_input_map_i == sbas_pkg::ENABLE_MAP_ALWAYS)
                          || !drive_enable_n_i;

  // Alarm latch: detection beats clear; encoder alarms ignore the pin clear
  wire logic clear_pin  = fault_clear_in_i || panel_clear_i;
  wire logic clear_ok   = clear_pin && !(enc_fault_reg || alarm_is_encoder_i);
  wire logic fault_next = alarm_detect_i || (fault_reg && !clear_ok);
  // Reset stands for loss of control power and clears everything
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_reg     <= 1'b0;
      enc_fault_reg <= 1'b0;
      code_reg      <= sbas_pkg::FAULT_CODE_NONE;
    end else begin
      fault_reg     <= fault_next;
      enc_fault_reg <= (alarm_detect_i && alarm_is_encoder_i) ||
                       (enc_fault_reg && !(alarm_detect_i && !alarm_is_encoder_i));
      if (alarm_detect_i && !fault_reg) begin
        code_reg <= alarm_type_i;
      end else if (!fault_next) begin
        code_reg <= sbas_pkg::FAULT_CODE_NONE;
      end
    end
  end

  // Turn-off request: enable removed or an alarm pending
  wire logic off_req   = !enable_req || fault_reg || alarm_detect_i;
  wire logic alarm_now = fault_reg || alarm_detect_i;

  // Clamp speed level to the motor maximum
  wire logic [13:0] level_eff = (brake_speed_level_i > motor_max_speed_i) ?
                                motor_max_speed_i : brake_speed_level_i;
  wire logic        below_lvl = (motor_speed_i < level_eff);

  // Clamp settings to their documented ranges
  wire logic [6:0] wait_set  = (brake_wait_time_i > sbas_pkg::WAIT_MAX) ?
                               sbas_pkg::WAIT_MAX : brake_wait_time_i;
  wire logic [5:0] delay_set = (brake_to_off_delay_i > sbas_pkg::OFF_DELAY_MAX) ?
                               sbas_pkg::OFF_DELAY_MAX : brake_to_off_delay_i;

  wire logic leave_run  = (state_reg == sbas_pkg::SBAS_RUN) && off_req;
  wire logic load_wait  = leave_run && !motor_stopped_i;
  wire logic load_delay = leave_run && motor_stopped_i && !alarm_now;

  sbas_tick_counter u_wait (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .load_i  (load_wait),
    .count_i (wait_set),
    .tick_i  (tick_reg),
    .done_o  (wait_done)
  );

  sbas_tick_counter u_delay (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .load_i  (load_delay),
    .count_i ({1'b0, delay_set}),
    .tick_i  (tick_reg),
    .done_o  (delay_done)
  );

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      sbas_pkg::SBAS_RUN: begin
        if (off_req) begin
          if (!motor_stopped_i) begin
            state_next = sbas_pkg::SBAS_RUNWAIT;
          end else if (alarm_now || (delay_set == 6'h00)) begin
            state_next = sbas_pkg::SBAS_OFF;
          end else begin
            state_next = sbas_pkg::SBAS_STOPWAIT;
          end
        end
      end
      sbas_pkg::SBAS_STOPWAIT: begin
        if (alarm_now || delay_done) begin
          state_next = sbas_pkg::SBAS_OFF;
        end
      end
      sbas_pkg::SBAS_RUNWAIT: begin
        if (below_lvl || wait_done) begin
          state_next = sbas_pkg::SBAS_OFF;
        end
      end
      sbas_pkg::SBAS_OFF: begin
        if (!off_req) begin
          state_next = sbas_pkg::SBAS_RUN;
        end
      end
    endcase
  end

  // Motor output and brake per state; alarm cuts motor power at once
  wire logic motor_next   = (state_next == sbas_pkg::SBAS_RUN) ||
                            ((state_next == sbas_pkg::SBAS_STOPWAIT) && !alarm_now);
  wire logic release_next = (state_next == sbas_pkg::SBAS_RUN) ||
                            (state_next == sbas_pkg::SBAS_RUNWAIT);

  // Placement decode, then OR with other signals on each circuit, active low
  wire logic [2:0] brake_sel = {brake_output_place_i == sbas_pkg::PLACE_THREE,
                                brake_output_place_i == sbas_pkg::PLACE_TWO,
                                brake_output_place_i == sbas_pkg::PLACE_ONE};
  wire logic [2:0] circ_next = ~((brake_sel & {3{release_next}}) |
                                 other_out_active_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg   <= sbas_pkg::SBAS_OFF;
      motor_reg   <= 1'b0;
      release_reg <= 1'b1;
      circ_n_reg  <= 3'h7;
    end else begin
      state_reg   <= state_next;
      motor_reg   <= motor_next;
      release_reg <= !release_next;
      circ_n_reg  <= circ_next;
    end
  end

  assign motor_output_on_o      = motor_reg;
  assign brake_release_out_o    = release_reg;
  assign output_circuit_n_o     = circ_n_reg;
  assign fault_out_n_o          = fault_reg;
  assign fault_code_bit_one_o   = code_reg[0];
  assign fault_code_bit_two_o   = code_reg[1];
  assign fault_code_bit_three_o = code_reg[2];

  a_alarm_stops_motor: assert property (@(posedge clk_i) disable iff (rst_i)
    alarm_detect_i |=> !motor_output_on_o)
    else $error("motor on after alarm");
  a_fault_sticks: assert property (@(posedge clk_i) disable iff (rst_i)
    alarm_detect_i |=> fault_out_n_o)
    else $error("fault out not set");
  a_clear_works: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_reg && !alarm_detect_i && fault_clear_in_i && !enc_fault_reg
    && !alarm_is_encoder_i |=> !fault_out_n_o)
    else $error("fault not cleared");
  a_enc_latched: assert property (@(posedge clk_i) disable iff (rst_i)
    enc_fault_reg && !alarm_detect_i |=> fault_out_n_o)
    else $error("encoder fault cleared");
  a_run_brake_free: assert property (@(posedge clk_i) disable iff (rst_i)
    motor_output_on_o |-> !brake_release_out_o || (state_reg == sbas_pkg::SBAS_STOPWAIT))
    else $error("motor runs on brake");
  a_zero_delay_same: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == sbas_pkg::SBAS_RUN) && off_req && motor_stopped_i
    && (delay_set == 6'h00) |=> !motor_output_on_o && brake_release_out_o)
    else $error("zero delay not simultaneous");
  a_speed_brake: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == sbas_pkg::SBAS_RUNWAIT) && below_lvl |=> brake_release_out_o)
    else $error("brake not applied below level");
  a_map_force: assert property (@(posedge clk_i) disable iff (rst_i)
    (enable_input_map_i == sbas_pkg::ENABLE_MAP_ALWAYS) && !alarm_detect_i && !fault_reg
    && (state_reg == sbas_pkg::SBAS_OFF) |=> motor_output_on_o)
    else $error("forced enable ignored");
  a_place_none: assert property (@(posedge clk_i) disable iff (rst_i)
    (brake_output_place_i == sbas_pkg::PLACE_NONE) |=> output_circuit_n_o ==
    ~$past(other_out_active_i))
    else $error("brake leaked to output");
  // Power loss leaves the brake applied and the motor unpowered
  a_reset_safe: assert property (@(posedge clk_i)
    rst_i |=> brake_release_out_o && !motor_output_on_o)
    else $error("reset state unsafe");
  // Power loss clears the fault output and code bits one and two
  a_reset_fault_clr: assert property (@(posedge clk_i)
    rst_i |=> !fault_out_n_o && !fault_code_bit_one_o && !fault_code_bit_two_o)
    else $error("reset left fault set");
  // Panel clear works like the pin clear
  a_panel_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_reg && !alarm_detect_i && panel_clear_i && !enc_fault_reg
    && !alarm_is_encoder_i |=> !fault_out_n_o)
    else $error("panel clear ignored");
  // First alarm latches its type onto the code outputs
  a_code_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    alarm_detect_i && !fault_reg |=> {fault_code_bit_three_o, fault_code_bit_two_o,
    fault_code_bit_one_o} == $past(alarm_type_i))
    else $error("alarm code not latched");
  // Later alarms must not overwrite the code of the first one
  a_code_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_reg && fault_next |=> $stable({fault_code_bit_three_o, fault_code_bit_two_o,
    fault_code_bit_one_o}))
    else $error("alarm code changed");
  // Off state means brake applied and motor unpowered
  a_off_outputs: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == sbas_pkg::SBAS_OFF) |-> brake_release_out_o && !motor_output_on_o)
    else $error("off state outputs wrong");
  // Moving turn-off cuts the motor but keeps the brake released
  a_runwait_outputs: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == sbas_pkg::SBAS_RUNWAIT) |-> !motor_output_on_o && !brake_release_out_o)
    else $error("running wait outputs wrong");
  // Standstill delay holds the brake applied while the motor stays on
  a_stopwait_brake: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == sbas_pkg::SBAS_STOPWAIT) |-> brake_release_out_o)
    else $error("brake released during delay");
  // Wait expiry applies the brake even above the speed level
  a_wait_expiry: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == sbas_pkg::SBAS_RUNWAIT) && wait_done |=> brake_release_out_o)
    else $error("brake not applied after wait");
  // Delay expiry stops the motor
  a_delay_expiry: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == sbas_pkg::SBAS_STOPWAIT) && delay_done |=> !motor_output_on_o)
    else $error("motor on after delay");
  // A level set above maximum still brakes once below the maximum
  a_level_clamp: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == sbas_pkg::SBAS_RUNWAIT) && (motor_speed_i < motor_max_speed_i)
    && (motor_speed_i < brake_speed_level_i) |=> brake_release_out_o)
    else $error("clamped level ignored");
  // Enable with no alarm restarts the motor and frees the brake
  a_enable_run: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == sbas_pkg::SBAS_OFF) && enable_req && !alarm_now
    |=> motor_output_on_o && !brake_release_out_o)
    else $error("enable did not run motor");
  // Placement one routes the released brake onto circuit one
  a_route_one: assert property (@(posedge clk_i) disable iff (rst_i)
    (brake_output_place_i == sbas_pkg::PLACE_ONE) && release_next |=> !output_circuit_n_o[0])
    else $error("brake not on circuit one");
  // Tick is a single-cycle strobe so counters step once per period
  a_tick_single: assert property (@(posedge clk_i) disable iff (rst_i)
    tick_reg |=> !tick_reg)
    else $error("tick longer than one cycle");
  // A zero wait expires at once after the turn-off
  a_wait_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    load_wait && (wait_set == 7'h00) |=> wait_done)
    else $error("zero wait not immediate");
endmodule
`default_nettype wire

/* File: test/sbas_host_model.sv */
// Host controller model: raises and removes alarm causes, pulses alarm reset
`timescale 1ns/1ps
`default_nettype none
module sbas_host_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic raise_i,
  input  wire logic clear_i,
  input  wire logic hold_clear_i,
  input  wire logic fault_out_n_i,
  output logic      alarm_detect_o,
  output logic      fault_clear_o,
  output logic      amp_power_on_o
);
  logic pend_reg;
  // Amplifier power is cut while the fault output is open
  assign amp_power_on_o = ~fault_out_n_i;
  // Cause goes away a cycle before the reset pulse, so the pulse is never wasted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_detect_o <= 1'b0;
      fault_clear_o  <= 1'b0;
      pend_reg       <= 1'b0;
    end else begin
      if (raise_i) alarm_detect_o <= 1'b1;
      else if (clear_i) alarm_detect_o <= 1'b0;
      pend_reg      <= clear_i & ~hold_clear_i;
      fault_clear_o <= pend_reg;
    end
  end
endmodule
`default_nettype wire

/* File: test/sbas_sequencer_bench.sv */
// Self-checking bench of the brake and fault sequencer
`timescale 1ns/1ps
`default_nettype none
module sbas_sequencer_bench;
  logic        clk_i, rst_i, den, pnl, enc, stp, raise, clr, hold;
  logic        det, fclr, motor, brk, fault, b1, b2, b3;
  logic [2:0]  map, typ, oth, circ, r;
  logic [13:0] spd, maxs, lvl;
  logic [5:0]  dly;
  logic [6:0]  wt;
  logic [1:0]  place;
  int          err_count = 0, checks_done = 0, cycles = 0, i;

  sbas_sequencer i_sbas_sequencer (.clk_i(clk_i), .rst_i(rst_i), .drive_enable_n_i(den),
    .enable_input_map_i(map), .fault_clear_in_i(fclr), .panel_clear_i(pnl),
    .alarm_detect_i(det), .alarm_type_i(typ), .alarm_is_encoder_i(enc),
    .motor_speed_i(spd), .motor_max_speed_i(maxs), .motor_stopped_i(stp),
    .brake_to_off_delay_i(dly), .brake_speed_level_i(lvl), .brake_wait_time_i(wt),
    .brake_output_place_i(place), .other_out_active_i(oth), .motor_output_on_o(motor),
    .brake_release_out_o(brk), .output_circuit_n_o(circ), .fault_out_n_o(fault),
    .fault_code_bit_one_o(b1), .fault_code_bit_two_o(b2), .fault_code_bit_three_o(b3));
  sbas_host_model i_sbas_host_model (.clk_i(clk_i), .rst_i(rst_i), .raise_i(raise),
    .clear_i(clr), .hold_clear_i(hold), .fault_out_n_i(fault), .alarm_detect_o(det),
    .fault_clear_o(fclr), .amp_power_on_o());

  // Clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 8000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk1(string n, logic e, logic g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic chk3(string n, logic [2:0] e, logic [2:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // Outputs are looked at on the falling edge, well after the flops settle
  task automatic look(int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic alarm(logic [2:0] t);
    @(posedge clk_i);
    raise <= 1'b1;
    typ <= t;
    @(posedge clk_i);
    raise <= 1'b0;
    look(1);
  endtask
  task automatic host_clear(logic h);
    @(posedge clk_i);
    clr <= 1'b1;
    hold <= h;
    @(posedge clk_i);
    clr <= 1'b0;
    look(2);
  endtask
  task automatic panel();
    @(posedge clk_i);
    pnl <= 1'b1;
    @(posedge clk_i);
    pnl <= 1'b0;
    look(1);
  endtask
  // Expected circuits with the brake released: low where any signal is active
  function automatic logic [2:0] exp_circ(int p, logic [2:0] o);
    int b;
    b = (p == 0) ? 0 : (1 << (p - 1));
    return ~(o | b[2:0]);
  endfunction

  initial begin
    void'($urandom(17337));
    {den, pnl, enc, raise, clr, hold} = 6'h00;
    rst_i = 1'b1;
    stp = 1'b1;
    {typ, oth, spd} = 20'h00000;
    maxs = 14'h07d0;
    map = sbas_pkg::ENABLE_MAP_INPUT;
    lvl = sbas_pkg::SPEED_LEVEL_DEF;
    dly = sbas_pkg::OFF_DELAY_DEF;
    wt = sbas_pkg::WAIT_DEF;
    place = sbas_pkg::PLACE_NONE;
    look(9);
    chk1("motor", 1'b0, motor);
    chk1("brake", 1'b1, brk);
    chk3("circuits", 3'h7, circ);
    chk1("fault", 1'b0, fault);
    @(posedge clk_i);
    rst_i <= 1'b0;
    look(2);
    chk1("motor", 1'b1, motor);
    chk1("brake", 1'b0, brk);
    for (i = 0; i < 4; i++) begin
      r = 3'($urandom);
      @(posedge clk_i);
      place <= 2'(i);
      oth <= r;
      look(2);
      chk3("circuits", exp_circ(i, r), circ);
    end
    @(posedge clk_i);
    map <= sbas_pkg::ENABLE_MAP_ALWAYS;
    den <= 1'b1;
    look(2);
    chk1("motor", 1'b1, motor);
    @(posedge clk_i);
    map <= sbas_pkg::ENABLE_MAP_INPUT;
    look(1);
    chk1("brake", 1'b1, brk);
    chk1("motor", 1'b0, motor);
    @(posedge clk_i);
    den <= 1'b0;
    look(2);
    chk1("motor", 1'b1, motor);
    @(posedge clk_i);
    dly <= sbas_pkg::OFF_DELAY_MAX;
    den <= 1'b1;
    look(1);
    chk1("brake", 1'b1, brk);
    look(500);
    chk1("motor", 1'b1, motor);
    r = 3'($urandom_range(7, 1));
    alarm(r);
    chk1("motor", 1'b0, motor);
    chk1("fault", 1'b1, fault);
    chk3("code", r, {b3, b2, b1});
    panel();
    chk1("fault", 1'b1, fault);
    host_clear(1'b1);
    chk1("fault", 1'b1, fault);
    panel();
    chk1("fault", 1'b0, fault);
    chk3("code", 3'h0, {b3, b2, b1});
    alarm(3'($urandom_range(7, 1)));
    host_clear(1'b0);
    chk1("fault", 1'b0, fault);
    @(posedge clk_i);
    enc <= 1'b1;
    alarm(r);
    host_clear(1'b0);
    chk1("fault", 1'b1, fault);
    @(posedge clk_i);
    rst_i <= 1'b1;
    enc <= 1'b0;
    den <= 1'b0;
    @(posedge clk_i);
    rst_i <= 1'b0;
    look(2);
    chk1("fault", 1'b0, fault);
    // Emergency turn-off while moving, level above motor maximum
    @(posedge clk_i);
    stp <= 1'b0;
    spd <= 14'h09c4;
    lvl <= 14'h1388;
    wt <= sbas_pkg::WAIT_MAX;
    den <= 1'b1;
    look(200);
    chk1("brake", 1'b0, brk);
    @(posedge clk_i);
    spd <= 14'h05dc;
    look(2);
    chk1("brake", 1'b1, brk);
    @(posedge clk_i);
    den <= 1'b0;
    look(3);
    chk1("motor", 1'b1, motor);
    @(posedge clk_i);
    wt <= 7'h00;
    spd <= 14'h0bb8;
    den <= 1'b1;
    look(2);
    chk1("brake", 1'b1, brk);
    @(posedge clk_i);
    den <= 1'b0;
    wt <= sbas_pkg::WAIT_MAX;
    lvl <= sbas_pkg::SPEED_LEVEL_DEF;
    look(3);
    alarm(r);
    chk1("motor", 1'b0, motor);
    chk1("brake", 1'b0, brk);
    @(posedge clk_i);
    spd <= 14'h0032;
    look(2);
    chk1("brake", 1'b1, brk);
    stop_test();
  end
endmodule
`default_nettype wire
